// ===== pmbc_debounce.sv
// Two-flop synchroniser and debouncer for a slow pin
`timescale 1ns/10ps
`default_nettype none
module pmbc_debounce #(
    parameter int unsigned DBC_CYC = pmbc_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Raw pin and clean level
    input wire logic pin,
    output var logic level
);
    localparam int W = pmbc_pkg::DBC_W;
    localparam logic [W-1:0] LAST = W'(DBC_CYC - 1);

    typedef struct packed {
        logic meta;
        logic sync;
        logic [W-1:0] cnt;
        logic level;
    } pmbc_dbc_s;

    pmbc_dbc_s r;
    pmbc_dbc_s next_r;

    // Level only moves after the pin stays put for the whole window
    always_comb begin
        next_r = r;
        next_r.meta = pin;
        next_r.sync = r.meta;
        if (r.sync == r.level) begin
            next_r.cnt = '0;
        end else if (r.cnt == LAST) begin
            next_r.level = r.sync;
            next_r.cnt = '0;
        end else begin
            next_r.cnt = r.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.level;
endmodule : pmbc_debounce
`default_nettype wire

// ===== pmbc_menu.sv
// Push-button menu controller: hold timing, presses, store and reset
`timescale 1ns/10ps
`default_nettype none
module pmbc_menu #(
    parameter int unsigned HOLD_CYC = pmbc_pkg::HOLD_CYC,
    parameter int unsigned BLINK_CYC = pmbc_pkg::BLINK_CYC,
    parameter int unsigned DBC_CYC = pmbc_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Pins: push button (high = pressed), variant strap
    input wire logic button_pin,
    input wire logic variant_pin,
    // Answers from the storage, start and reset engines
    input wire pmbc_pkg::pmbc_rsp_s rsp,
    // LED colours
    output var pmbc_pkg::pmbc_led_s led,
    // Requests to the engines
    output var pmbc_pkg::pmbc_req_s req,
    // Active fieldbus protocol, 1 = EtherNet/IP
    output var logic protocol
);
    localparam int TW = pmbc_pkg::TMR_W;
    localparam int BW = pmbc_pkg::BLK_W;
    localparam int CW = pmbc_pkg::CNT_W;
    localparam logic [TW-1:0] HOLD_END = TW'(HOLD_CYC - 1);
    localparam logic [BW-1:0] BLINK_END = BW'(BLINK_CYC - 1);

    typedef struct packed {
        pmbc_pkg::pmbc_state_e state;
        logic [TW-1:0] tmr;
        logic [BW-1:0] blink_cnt;
        logic blink;
        logic btn_q;
        logic wait_rel;
        logic hold_seen;
        logic [CW-1:0] presses;
        logic [1:0] seg_sel;
        logic ok;
        logic protocol;
        pmbc_pkg::pmbc_led_s led;
        pmbc_pkg::pmbc_req_s req;
    } pmbc_ctl_s;

    pmbc_ctl_s r;
    pmbc_ctl_s next_r;
    logic btn;
    logic variant;
    logic press;
    logic release_ev;
    logic expire;
    logic hold_hit;
    logic proto_sel;
    logic proto_val;
    logic [1:0] seg;

    // =========================================================
    // Pin conditioning
    pmbc_debounce #(
        .DBC_CYC(DBC_CYC)
    ) u_button (
        .clock(clock),
        .rst_b(rst_b),
        .pin(button_pin),
        .level(btn)
    );

    // Strap shares the filter so it is synchronised the same way
    pmbc_debounce #(
        .DBC_CYC(DBC_CYC)
    ) u_variant (
        .clock(clock),
        .rst_b(rst_b),
        .pin(variant_pin),
        .level(variant)
    );

    // =========================================================
    // Decoded events
    assign press = btn & ~r.btn_q;
    assign release_ev = ~btn & r.btn_q;
    // One shared timer: hold length while pressed, idle while released
    assign expire = (r.tmr == HOLD_END - 1'b1);
    assign hold_hit = expire & btn;
    assign seg = (r.presses == '0) ? pmbc_pkg::SEG_1 :
                 (r.presses == pmbc_pkg::STD_PN) ? pmbc_pkg::SEG_2 :
                 pmbc_pkg::SEG_BOTH;
    // Standard unit shares counts with segments; pick only if it changes
    assign proto_sel = variant ?
        (r.presses == pmbc_pkg::EXT_PN ||
         r.presses == pmbc_pkg::EXT_EIP) :
        ((r.presses == pmbc_pkg::STD_PN &&
          r.protocol != pmbc_pkg::PROTO_PN) ||
         (r.presses == pmbc_pkg::STD_EIP &&
          r.protocol != pmbc_pkg::PROTO_EIP));
    assign proto_val = variant ? (r.presses == pmbc_pkg::EXT_EIP) :
                       (r.presses == pmbc_pkg::STD_EIP);

    // Colour shown only in the lit half of the blink period
    function automatic pmbc_pkg::pmbc_color_e flash(
        input pmbc_pkg::pmbc_color_e c,
        input logic on
    );
        flash = on ? c : pmbc_pkg::C_OFF;
    endfunction : flash

    // =========================================================
    // Next-state logic
    always_comb begin
        next_r = r;
        next_r.req = '0;
        next_r.led = '0;
        next_r.btn_q = btn;
        // Blink base
        if (r.blink_cnt == BLINK_END) begin
            next_r.blink_cnt = '0;
            next_r.blink = ~r.blink;
        end else begin
            next_r.blink_cnt = r.blink_cnt + 1'b1;
        end
        // Timer saturates so each run expires once
        if (r.tmr != HOLD_END) begin
            next_r.tmr = r.tmr + 1'b1;
        end
        if (press || release_ev) begin
            next_r.tmr = '0;
        end
        unique case (r.state)
            pmbc_pkg::ST_PWRUP: begin
                // Ready flag is stale for the cycle the restart goes out
                if (rsp.start_done && !r.req.restart) begin
                    if (btn) begin
                        next_r.state = pmbc_pkg::ST_FR_MENU;
                        next_r.wait_rel = 1'b1;
                        next_r.hold_seen = 1'b0;
                    end else begin
                        next_r.state = pmbc_pkg::ST_IDLE;
                    end
                end
            end
            pmbc_pkg::ST_IDLE: begin
                if (hold_hit) begin
                    next_r.state = pmbc_pkg::ST_MENU;
                    next_r.presses = '0;
                    next_r.wait_rel = 1'b1;
                end
            end
            pmbc_pkg::ST_MENU: begin
                if (seg[0]) begin
                    next_r.led.line1_led = flash(pmbc_pkg::C_YELLOW, r.blink);
                end
                if (seg[1]) begin
                    next_r.led.line2_led = flash(pmbc_pkg::C_YELLOW,
                                                 r.blink);
                end
                if (proto_sel) begin
                    next_r.led.fault_status_led =
                        flash(pmbc_pkg::C_YELLOW, r.blink);
                end
                if (release_ev) begin
                    // Release that ends the opening hold is not a press
                    if (r.wait_rel) begin
                        next_r.wait_rel = 1'b0;
                    end else if (r.tmr != HOLD_END &&
                                 r.presses != pmbc_pkg::CNT_MAX) begin
                        next_r.presses = r.presses + 1'b1;
                    end
                end else if (hold_hit && proto_sel) begin
                    next_r.state = pmbc_pkg::ST_PROTO;
                    next_r.protocol = proto_val;
                    next_r.req.fb_clear = 1'b1;
                    next_r.tmr = '0;
                end else if (hold_hit) begin
                    next_r.state = pmbc_pkg::ST_STORE;
                    next_r.seg_sel = seg;
                    next_r.req.store_req = 1'b1;
                    next_r.req.protect_req = 1'b1;
                    next_r.req.seg_sel = seg;
                end else if (expire && !btn) begin
                    next_r.state = pmbc_pkg::ST_IDLE;
                end
            end
            pmbc_pkg::ST_STORE: begin
                if (rsp.store_done) begin
                    next_r.state = pmbc_pkg::ST_RESULT;
                    next_r.ok = rsp.store_ok;
                    next_r.tmr = '0;
                end
            end
            pmbc_pkg::ST_RESULT: begin
                // Button ignored while the result is on show
                next_r.tmr = (r.tmr == HOLD_END) ? r.tmr : r.tmr + 1'b1;
                if (r.seg_sel == pmbc_pkg::SEG_BOTH) begin
                    next_r.led.memory_led = r.ok ? pmbc_pkg::C_GREEN :
                                            pmbc_pkg::C_RED;
                end else if (r.seg_sel[0]) begin
                    next_r.led.line1_led = flash(r.ok ? pmbc_pkg::C_GREEN :
                        pmbc_pkg::C_RED, r.blink);
                end else begin
                    next_r.led.line2_led = flash(r.ok ? pmbc_pkg::C_GREEN :
                        pmbc_pkg::C_RED, r.blink);
                end
                if (expire) begin
                    next_r.state = pmbc_pkg::ST_IDLE;
                end
            end
            pmbc_pkg::ST_PROTO: begin
                next_r.tmr = (r.tmr == HOLD_END) ? r.tmr : r.tmr + 1'b1;
                next_r.led.line1_led = flash(pmbc_pkg::C_YELLOW, r.blink);
                next_r.led.line2_led = flash(pmbc_pkg::C_YELLOW,
                                             r.blink);
                if (expire) begin
                    next_r.state = pmbc_pkg::ST_RESTART;
                end
            end
            pmbc_pkg::ST_FR_MENU: begin
                next_r.led.fault_status_led =
                    flash(pmbc_pkg::C_YELLOW, r.blink);
                if (release_ev) begin
                    if (r.wait_rel) begin
                        next_r.wait_rel = 1'b0;
                    end else if (r.hold_seen) begin
                        next_r.state = pmbc_pkg::ST_FR_BUSY;
                        next_r.req.factory_req = 1'b1;
                    end
                end else if (hold_hit && !r.wait_rel) begin
                    next_r.hold_seen = 1'b1;
                end else if (expire && !btn && !r.hold_seen) begin
                    next_r.state = pmbc_pkg::ST_RESTART;
                end
            end
            pmbc_pkg::ST_FR_BUSY: begin
                if (rsp.reset_done) begin
                    next_r.tmr = '0;
                    next_r.state = rsp.reset_ok ? pmbc_pkg::ST_RESTART :
                                   pmbc_pkg::ST_FR_ERR;
                end
            end
            pmbc_pkg::ST_FR_ERR: begin
                next_r.tmr = (r.tmr == HOLD_END) ? r.tmr : r.tmr + 1'b1;
                next_r.led.button_fn_led =
                    flash(pmbc_pkg::C_RED, r.blink);
                if (expire) begin
                    next_r.state = pmbc_pkg::ST_RESTART;
                end
            end
            pmbc_pkg::ST_RESTART: begin
                next_r.req.restart = 1'b1;
                next_r.state = pmbc_pkg::ST_PWRUP;
            end
            default: begin
                next_r.state = pmbc_pkg::ST_IDLE;
            end
        endcase
    end

    // =========================================================
    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.state <= pmbc_pkg::ST_PWRUP;
            r.protocol <= pmbc_pkg::PROTO_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign led = r.led;
    assign req = r.req;
    assign protocol = r.protocol;

    // =========================================================
    // Checks
    menu_open_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        r.state == pmbc_pkg::ST_IDLE && hold_hit
        |=> r.state == pmbc_pkg::ST_MENU && r.presses == '0)
        else $error("hold did not open the menu");

    store_request_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        r.state == pmbc_pkg::ST_MENU && hold_hit && !proto_sel
        && !release_ev
        |=> req.store_req && req.protect_req && req.seg_sel == r.seg_sel)
        else $error("store request missing");

    result_entry_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        r.state == pmbc_pkg::ST_STORE && rsp.store_done
        |=> r.state == pmbc_pkg::ST_RESULT && r.tmr == '0
        ##1 r.tmr == 1)
        else $error("result timer not started");

    seg2_led_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        r.state == pmbc_pkg::ST_MENU && r.presses == 3'h1 && r.blink
        |=> led.line2_led == pmbc_pkg::C_YELLOW
        && led.line1_led == pmbc_pkg::C_OFF)
        else $error("segment 2 not shown");

    both_led_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        r.state == pmbc_pkg::ST_MENU && r.presses == 3'h2 && r.blink
        |=> led.line1_led == pmbc_pkg::C_YELLOW
        && led.line2_led == pmbc_pkg::C_YELLOW)
        else $error("both segments not shown");

    memory_led_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        r.state == pmbc_pkg::ST_RESULT && r.seg_sel == pmbc_pkg::SEG_BOTH
        |=> led.memory_led == (r.ok ? pmbc_pkg::C_GREEN : pmbc_pkg::C_RED))
        else $error("memory LED wrong");

    menu_timeout_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        r.state == pmbc_pkg::ST_MENU && expire && !btn && !r.btn_q
        |=> r.state == pmbc_pkg::ST_IDLE)
        else $error("menu not left after idle time");

    proto_change_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        $changed(protocol)
        |-> $past(r.state) == pmbc_pkg::ST_MENU && req.fb_clear)
        else $error("protocol changed outside menu");

    fr_entry_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        r.state == pmbc_pkg::ST_PWRUP && rsp.start_done && btn
        && !req.restart
        |=> r.state == pmbc_pkg::ST_FR_MENU ##1
        led.fault_status_led == ($past(r.blink) ? pmbc_pkg::C_YELLOW :
                                 pmbc_pkg::C_OFF))
        else $error("factory menu not entered");

    fr_timeout_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        r.state == pmbc_pkg::ST_FR_MENU && expire && !btn && !r.btn_q
        && !r.hold_seen
        |=> r.state == pmbc_pkg::ST_RESTART ##1 req.restart
        && !req.factory_req)
        else $error("factory menu idle restart missing");

    fr_error_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        r.state == pmbc_pkg::ST_FR_BUSY && rsp.reset_done && !rsp.reset_ok
        |=> r.state == pmbc_pkg::ST_FR_ERR)
        else $error("factory reset error not shown");
endmodule : pmbc_menu
`default_nettype wire

// ===== pmbc_operator.sv
// Operator and engine model facing the push-button menu controller
`timescale 1ns/10ps
`default_nettype none
module pmbc_operator (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Requests from the block
    input wire pmbc_pkg::pmbc_req_s req,
    // Pins and engine answers
    output var logic button_pin,
    output var logic variant_pin,
    output var pmbc_pkg::pmbc_rsp_s rsp
);
    // ========================================
    // Operator actions
    logic ok = 1'h1;
    int ps = 0;
    int pr = 0;
    int up = 0;

    // Pin level set just after an edge, then kept for n edges
    task automatic level(input logic v, input int n);
        @(posedge clock);
        button_pin <= v;
        repeat (n) @(posedge clock);
    endtask : level

    // Held well past the hold time, then let go
    task automatic hold();
        level(1'h1, 55);
        level(1'h0, 12);
    endtask : hold

    // Let go long before the hold time, so it counts as one press
    // Release gap spans several blink periods but stays under the timeout
    task automatic tap();
        level(1'h1, 10);
        level(1'h0, 20);
    endtask : tap

    // ========================================
    // Engines answer late; result flags lie outside their done cycle
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rsp <= '0;
            ps <= 0;
            pr <= 0;
            up <= 0;
        end else begin
            rsp.store_done <= (ps == 1);
            rsp.reset_done <= (pr == 1);
            rsp.store_ok <= (ps == 1) ? ok : ~ok;
            rsp.reset_ok <= (pr == 1) ? ok : ~ok;
            rsp.start_done <= !req.restart && (up >= 20); // Drops on restart
            ps <= req.store_req ? 5 : (ps > 0 ? ps - 1 : 0);
            pr <= req.factory_req ? 5 : (pr > 0 ? pr - 1 : 0);
            up <= req.restart ? 0 : (up < 20 ? up + 1 : up);
        end
    end
endmodule : pmbc_operator
`default_nettype wire

// ===== pmbc_pkg.sv
// Constants and types shared by the push-button menu controller
package pmbc_pkg;
    // =========================================================

    // =========================================================
    // Timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned HOLD_MS = 5000;
    localparam int unsigned HOLD_CYC = HOLD_MS * CYC_PER_MS;
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYC = BLINK_MS * CYC_PER_MS;
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
    localparam int TMR_W = 29;
    localparam int BLK_W = 25;
    localparam int DBC_W = 20;
    localparam int CNT_W = 3;

    // =========================================================
    // Press counts, segments, protocols
    localparam logic [CNT_W-1:0] CNT_MAX = 3'h4;
    localparam logic [CNT_W-1:0] STD_PN = 3'h1;
    localparam logic [CNT_W-1:0] STD_EIP = 3'h2;
    localparam logic [CNT_W-1:0] EXT_PN = 3'h3;
    localparam logic [CNT_W-1:0] EXT_EIP = 3'h4;
    localparam logic [1:0] SEG_1 = 2'h1;
    localparam logic [1:0] SEG_2 = 2'h2;
    localparam logic [1:0] SEG_BOTH = 2'h3;
    localparam logic PROTO_PN = 1'h0;
    localparam logic PROTO_EIP = 1'h1;
    localparam logic PROTO_RESET = PROTO_PN;

    // =========================================================
    // Types
    typedef enum logic [1:0] {
        C_OFF = 2'b00,
        C_GREEN = 2'b01,
        C_RED = 2'b10,
        C_YELLOW = 2'b11
    } pmbc_color_e;

    typedef enum logic [3:0] {
        ST_PWRUP = 4'b0000,
        ST_IDLE = 4'b0001,
        ST_MENU = 4'b0010,
        ST_STORE = 4'b0011,
        ST_RESULT = 4'b0100,
        ST_PROTO = 4'b0101,
        ST_FR_MENU = 4'b0110,
        ST_FR_BUSY = 4'b0111,
        ST_FR_ERR = 4'b1000,
        ST_RESTART = 4'b1001
    } pmbc_state_e;

    typedef struct packed {
        pmbc_color_e line1_led;
        pmbc_color_e line2_led;
        pmbc_color_e memory_led;
        pmbc_color_e fault_status_led;
        pmbc_color_e button_fn_led;
    } pmbc_led_s;

    typedef struct packed {
        logic store_req;
        logic [1:0] seg_sel;
        logic protect_req;
        logic fb_clear;
        logic factory_req;
        logic restart;
    } pmbc_req_s;

    typedef struct packed {
        logic start_done;
        logic store_done;
        logic store_ok;
        logic reset_done;
        logic reset_ok;
    } pmbc_rsp_s;
endpackage : pmbc_pkg

// ===== test_pushbutton_menu_controller.sv
// Self-checking testbench for the push-button menu controller
`timescale 1ns/10ps
`default_nettype none
module test_pushbutton_menu_controller;
    // ========================================
    // Signals and bookkeeping
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic button_pin;
    logic variant_pin;
    logic protocol;
    pmbc_pkg::pmbc_rsp_s rsp;
    pmbc_pkg::pmbc_led_s led;
    pmbc_pkg::pmbc_req_s req;
    int errors = 0;
    int checked = 0;
    logic [3:0] s_l1, s_l2, s_mem, s_fs, s_bf;
    logic s_st, s_pr, s_fb, s_fr, s_rs;
    logic [1:0] s_sel;

    // Short counts keep the run small
    pmbc_menu #(.HOLD_CYC(40), .BLINK_CYC(4), .DBC_CYC(3)) dut_u (
        .clock(clock), .rst_b(rst_b), .button_pin(button_pin),
        .variant_pin(variant_pin), .rsp(rsp), .led(led), .req(req),
        .protocol(protocol));
    pmbc_operator op_u (
        .clock(clock), .rst_b(rst_b), .req(req), .button_pin(button_pin),
        .variant_pin(variant_pin), .rsp(rsp));

    // Clock at 100 MHz
    initial begin
        forever #5 clock = ~clock;
    end

    // Sticky record of colours shown and requests issued
    always @(posedge clock) begin
        s_l1[led.line1_led] <= 1'h1;
        s_l2[led.line2_led] <= 1'h1;
        s_mem[led.memory_led] <= 1'h1;
        s_fs[led.fault_status_led] <= 1'h1;
        s_bf[led.button_fn_led] <= 1'h1;
        if (req.store_req) begin
            s_sel <= req.seg_sel;
            s_pr <= req.protect_req;
        end
        s_st <= s_st | req.store_req;
        s_fb <= s_fb | req.fb_clear;
        s_fr <= s_fr | req.factory_req;
        s_rs <= s_rs | req.restart;
    end

    // ========================================
    // Shared tasks
    // Cleared on the falling edge, away from the recording edge
    task automatic clr();
        @(negedge clock);
        {s_l1, s_l2, s_mem, s_fs, s_bf} = '0;
        {s_st, s_pr, s_fb, s_fr, s_rs, s_sel} = '0;
    endtask : clr

    task automatic chk(input string what, input logic [3:0] exp,
            input logic [3:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // Start-up also waits for the engines to report ready
    task automatic do_reset(input logic var_v, input logic btn);
        @(posedge clock);
        rst_b <= 1'h0;
        op_u.variant_pin <= var_v;
        op_u.button_pin <= btn;
        repeat (3) @(posedge clock);
        rst_b <= 1'h1;
        repeat (30) @(posedge clock);
        clr();
    endtask : do_reset

    task automatic conclude();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // ========================================
    // Scenarios
    task automatic t_reset();
        do_reset(1'h1, 1'h0);
        chk("protocol", 4'h0, {3'h0, protocol});
        chk("line1", 4'h0, {2'h0, led.line1_led});
        $display("test reset done");
    endtask : t_reset

    // A one-cycle glitch before the store hold must not count
    task automatic t_seg1();
        op_u.ok = 1'h1;
        clr();
        op_u.hold();
        chk("line1 yellow", 4'h1, {3'h0, s_l1[3]});
        op_u.level(1'h1, 0);
        op_u.level(1'h0, 10);
        op_u.hold();
        chk("seg_sel", 4'h1, {2'h0, s_sel});
        chk("protect", 4'h1, {3'h0, s_pr});
        chk("line1 green", 4'h1, {2'h0, s_l1[2:1]});
        repeat (60) @(posedge clock);
        chk("line1 end", 4'h0, {2'h0, led.line1_led});
        $display("test seg1 done");
    endtask : t_seg1

    task automatic t_seg2();
        op_u.ok = 1'h0;
        clr();
        op_u.hold();
        op_u.tap();
        chk("line2 yellow", 4'h1, {3'h0, s_l2[3]});
        op_u.hold();
        chk("seg_sel", 4'h2, {2'h0, s_sel});
        chk("line2 red", 4'h1, {3'h0, s_l2[2]});
        repeat (60) @(posedge clock);
        $display("test seg2 done");
    endtask : t_seg2

    task automatic t_both();
        op_u.ok = 1'h1;
        op_u.hold();
        op_u.tap();
        clr();
        op_u.tap();
        chk("both yellow", 4'h3, {2'h0, s_l1[3], s_l2[3]});
        op_u.hold();
        chk("seg_sel", 4'h3, {2'h0, s_sel});
        chk("memory green", 4'h1, {3'h0, s_mem[1]});
        repeat (60) @(posedge clock);
        $display("test both done");
    endtask : t_both

    // After the idle timeout a hold opens the menu instead of storing
    task automatic t_timeout();
        op_u.hold();
        repeat (60) @(posedge clock);
        clr();
        repeat (10) @(posedge clock);
        chk("line1 idle", 4'h1, s_l1);
        op_u.hold();
        chk("no store", 4'h0, {3'h0, s_st});
        repeat (60) @(posedge clock);
        $display("test timeout done");
    endtask : t_timeout

    task automatic t_std_proto();
        do_reset(1'h0, 1'h0);
        op_u.hold();
        op_u.tap();
        op_u.tap();
        chk("status flash", 4'h1, {3'h0, |s_fs[3:1]});
        op_u.hold();
        chk("protocol", 4'h1, {3'h0, protocol});
        chk("fb clear", 4'h1, {3'h0, s_fb});
        repeat (70) @(posedge clock);
        chk("restart", 4'h1, {3'h0, s_rs});
        op_u.hold();
        op_u.tap();
        op_u.hold();
        chk("protocol", 4'h0, {3'h0, protocol});
        repeat (70) @(posedge clock);
        $display("test standard protocol done");
    endtask : t_std_proto

    task automatic t_ext_proto();
        do_reset(1'h1, 1'h0);
        op_u.hold();
        repeat (4) op_u.tap();
        op_u.hold();
        chk("protocol", 4'h1, {3'h0, protocol});
        repeat (70) @(posedge clock);
        op_u.hold();
        repeat (3) op_u.tap();
        op_u.hold();
        chk("protocol", 4'h0, {3'h0, protocol});
        repeat (70) @(posedge clock);
        $display("test extended protocol done");
    endtask : t_ext_proto

    // Factory reset, passing when ok is set and failing otherwise
    task automatic t_factory(input logic ok);
        op_u.ok = ok;
        do_reset(1'h1, 1'h1);
        repeat (20) @(posedge clock);
        chk("status yellow", 4'h1, {3'h0, s_fs[3]});
        op_u.level(1'h0, 12);
        op_u.hold();
        repeat (60) @(posedge clock);
        chk("factory req", 4'h1, {3'h0, s_fr});
        chk("restart", 4'h1, {3'h0, s_rs});
        chk("button red", {3'h0, ~ok}, {3'h0, s_bf[2]});
        $display("test factory reset done");
    endtask : t_factory

    task automatic t_fr_idle();
        do_reset(1'h1, 1'h1);
        op_u.level(1'h0, 70);
        chk("restart", 4'h1, {3'h0, s_rs});
        chk("no factory", 4'h0, {3'h0, s_fr});
        $display("test factory idle done");
    endtask : t_fr_idle

    // ========================================
    // Main sequence and watchdog
    initial begin
        t_reset();
        t_seg1();
        t_seg2();
        t_both();
        t_timeout();
        t_std_proto();
        t_ext_proto();
        t_factory(1'h1);
        t_factory(1'h0);
        t_fr_idle();
        conclude();
    end

    // About seven times the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        conclude();
    end
endmodule : test_pushbutton_menu_controller
`default_nettype wire
